// File: hw/sar_adc_ctrl.sv
// Conversion control, APB registers and result handling
`timescale 1ns/1ps
// What this block does
// - Converter disabled during reset and, with software trigger, when channel select is all ones
// - Idle in lowest power after completion until a new start
// - Approximation yields 11 bits in 10-bit mode, 9 in 8-bit mode
// - 10-bit result spans high and low; 8-bit result in low only
// - Result transfer sets done flag and interrupt if enabled
// - Compare enable checks every result against compare value
// - Compare supports less-than and greater-or-equal with interrupt
// - Two-bit clock select picks four sources, then divided
// - Clock select resets to undivided bus clock
// - Halved bus clock with divider reaches divide by 16
// - Async clock keeps running in wait and stop3
// - High read without low read blocks new 10-bit results
// - Blocked transfer restarts, except single false-compare which ends
// - Writing control 1 aborts; in software-trigger mode it restarts unless channel all ones
// - Writing control 2, config or compare values aborts conversion
// - Reset, or stop without async clock, aborts conversion
// - Abort keeps last results; reset clears them
// - Async clock generator on only when converting with it selected
// - Sample short or long, then isolate and approximate
// - Pin control 3 bits 1,0 disable pin I/O for channels 17,16
// - Single, continuous and hardware-triggered conversion
module sar_adc_ctrl
(
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        ALT_TICK_I,
  input  wire logic        ASYNC_TICK_I,
  input  wire logic        HW_TRIGGER_I,
  input  wire logic        STOP_I,
  input  wire logic        WAIT_I,
  input  wire logic        COMP_I,
  output logic      [4:0]  CHANNEL_O,
  output logic             SAMPLE_O,
  output logic      [10:0] DAC_CODE_O,
  output logic             ANALOG_EN_O,
  output logic             LOW_POWER_O,
  output logic             ASYNC_CLK_EN_O,
  output logic      [7:0]  PIN_DISABLE_O,
  output logic             IRQ_O
);
  sar_tick_if tk ();

  logic [7:0]  sc1_r;
  logic [7:0]  sc2_r;
  logic [7:0]  cfg_r;
  logic [7:0]  cvh_r;
  logic [7:0]  cvl_r;
  logic [7:0]  pc3_r;
  logic [7:0]  rh_r;
  logic [7:0]  rl_r;
  logic        hi_read_r;
  logic        trig_d_r;
  sar_ctrl_pkg::conv_state_t st_r;
  sar_ctrl_pkg::conv_state_t st_nxt;
  logic [4:0]  smp_cnt_r;
  logic [10:0] sar_r;
  logic [3:0]  bit_r;

  wire        acc     = PSEL_I & PENABLE_I;
  wire        wr      = acc & PWRITE_I;
  wire        rd      = acc & ~PWRITE_I;
  wire        wr_sc1  = wr & (PADDR_I == sar_ctrl_pkg::ADDR_SC1);
  wire        wr_sc2  = wr & (PADDR_I == sar_ctrl_pkg::ADDR_SC2);
  wire        wr_cfg  = wr & (PADDR_I == sar_ctrl_pkg::ADDR_CFG);
  wire        wr_cvh  = wr & (PADDR_I == sar_ctrl_pkg::ADDR_CV_HI);
  wire        wr_cvl  = wr & (PADDR_I == sar_ctrl_pkg::ADDR_CV_LO);
  wire        wr_pc3  = wr & (PADDR_I == sar_ctrl_pkg::ADDR_PC3);
  wire        rd_rh   = rd & (PADDR_I == sar_ctrl_pkg::ADDR_RES_HI);
  wire        rd_rl   = rd & (PADDR_I == sar_ctrl_pkg::ADDR_RES_LO);
  wire        mapped  = PADDR_I[1:0] == 2'h0 && PADDR_I <= sar_ctrl_pkg::ADDR_PC3;

  wire [4:0]  ch      = sc1_r[sar_ctrl_pkg::CH_W-1:0];
  wire        ch_off  = ch == sar_ctrl_pkg::CH_ALL_ONES;
  wire        cont    = sc1_r[sar_ctrl_pkg::SC1_CONT_BIT];
  wire        hw_trg  = sc2_r[sar_ctrl_pkg::SC2_TRG_BIT];
  wire        cmp_en  = sc2_r[sar_ctrl_pkg::SC2_CFE_BIT];
  wire        cmp_ge  = sc2_r[sar_ctrl_pkg::SC2_CFGT_BIT];
  wire [1:0]  mode    = cfg_r[sar_ctrl_pkg::CFG_MODE_LSB +: 2];
  wire        ten     = mode == sar_ctrl_pkg::MODE_10;
  wire [1:0]  clk_src = cfg_r[sar_ctrl_pkg::CFG_CLK_LSB +: 2];
  wire        async_s = clk_src == sar_ctrl_pkg::CLK_ASYNC;

  // Abort on mode change or stop without the async clock
  wire        mode_ab = wr_sc2 | wr_cfg | wr_cvh | wr_cvl;
  wire        stop_ab = STOP_I & ~async_s;
  wire        abort   = wr_sc1 | mode_ab | stop_ab;
  wire        trg_edg = HW_TRIGGER_I & ~trig_d_r;
  // Software start is a control 1 write; hardware start is a trigger edge
  wire        start   = hw_trg ? (trg_edg & ~stop_ab)
                               : (wr_sc1 & PWDATA_I[4:0] != sar_ctrl_pkg::CH_ALL_ONES);

  wire [10:0] try_bit = 11'(11'h001 << bit_r);
  wire [10:0] sar_nx  = COMP_I ? sar_r : 11'(sar_r & ~try_bit);
  // Round the decided value: the last trial bit is judged in this cycle
  // Round: add extra bit then drop it, saturating at full scale
  wire [3:0]  nbits   = ten ? 4'hb : 4'h9;
  wire [11:0] sum10   = {1'b0, sar_nx} + 12'h001;
  wire [9:0]  res10   = sum10[11] ? 10'h3ff : sum10[10:1];
  wire [9:0]  sum8    = {1'b0, sar_nx[8:0]} + 10'h001;
  wire [7:0]  res8    = sum8[9] ? 8'hff : sum8[8:1];
  wire [9:0]  result  = ten ? res10 : {2'h0, res8};
  wire [9:0]  cmpval  = ten ? {cvh_r[1:0], cvl_r} : {2'h0, cvl_r};
  // Compare: less-than or greater-or-equal
  wire        cmp_ok  = ~cmp_en | (cmp_ge ? result >= cmpval : result < cmpval);
  wire        blocked = ten & hi_read_r;
  wire        last_bit= tk.tick & st_r == sar_ctrl_pkg::ST_CONV && bit_r == 4'h0;
  wire        xfer    = last_bit & cmp_ok & ~blocked;
  // Blocked result relaunches, except a failing single compare
  wire        relaunch= last_bit & ((blocked & ~(~cont & cmp_en & ~cmp_ok))
                                    | (cont & ~blocked));
  wire        smp_end = smp_cnt_r == 5'h00;
  wire        step    = tk.tick && st_r == sar_ctrl_pkg::ST_CONV
                        && bit_r != 4'h0;
  // Code pin and sar_r share one next value, so the comparator never
  // judges a stale trial code
  wire [10:0] sar_nxt =
    (st_r == sar_ctrl_pkg::ST_SAMPLE) ? 11'(11'h001 << (nbits - 4'h1)) :
    step     ? (sar_nx | 11'(11'h001 << (bit_r - 4'h1))) :
    last_bit ? sar_nx : sar_r;

  assign tk.run        = st_r == sar_ctrl_pkg::ST_SAMPLE || st_r == sar_ctrl_pkg::ST_CONV;
  assign tk.src        = clk_src;
  assign tk.div        = cfg_r[sar_ctrl_pkg::CFG_DIV_LSB +: 2];
  assign tk.alt_tick   = ALT_TICK_I;
  assign tk.async_tick = ASYNC_TICK_I;

  sar_clk_div u_div
  (
    .CLK_I     (CLK_I),
    .RESET_N_I (RESET_N_I),
    .t         (tk)
  );

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      sar_ctrl_pkg::ST_IDLE:
        if (start)
          st_nxt = sar_ctrl_pkg::ST_SAMPLE;
      sar_ctrl_pkg::ST_SAMPLE:
        if (tk.tick && smp_end)
          st_nxt = sar_ctrl_pkg::ST_CONV;
      sar_ctrl_pkg::ST_CONV:
        if (last_bit)
          st_nxt = relaunch ? sar_ctrl_pkg::ST_SAMPLE : sar_ctrl_pkg::ST_DONE;
      sar_ctrl_pkg::ST_DONE:
        st_nxt = sar_ctrl_pkg::ST_IDLE;
      default:
        st_nxt = sar_ctrl_pkg::ST_IDLE;
    endcase
    if (abort)
      st_nxt = start ? sar_ctrl_pkg::ST_SAMPLE : sar_ctrl_pkg::ST_IDLE;
    else if (st_nxt == sar_ctrl_pkg::ST_IDLE && start)
      st_nxt = sar_ctrl_pkg::ST_SAMPLE;
  end

  // Sequencer
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      st_r      <= sar_ctrl_pkg::ST_IDLE;
      smp_cnt_r <= sar_ctrl_pkg::SAMPLE_SHORT;
      sar_r     <= 11'h000;
      bit_r     <= 4'h0;
      trig_d_r  <= 1'b0;
    end
    else
    begin
      st_r     <= st_nxt;
      trig_d_r <= HW_TRIGGER_I;
      if (st_nxt == sar_ctrl_pkg::ST_SAMPLE && st_r != sar_ctrl_pkg::ST_SAMPLE)
        smp_cnt_r <= cfg_r[sar_ctrl_pkg::CFG_LSMP_BIT] ?
                     sar_ctrl_pkg::SAMPLE_LONG : sar_ctrl_pkg::SAMPLE_SHORT;
      else if (tk.tick && !smp_end)
        smp_cnt_r <= 5'(smp_cnt_r - 5'h01);
      sar_r <= sar_nxt;
      if (st_r == sar_ctrl_pkg::ST_SAMPLE)
        bit_r <= 4'(nbits - 4'h1);
      else if (step)
        bit_r <= 4'(bit_r - 4'h1);
    end
  end

  // Software-written registers
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      sc1_r <= {3'h0, sar_ctrl_pkg::CH_RESET};
      sc2_r <= sar_ctrl_pkg::REG_ZERO;
      cfg_r <= sar_ctrl_pkg::REG_ZERO;
      cvh_r <= sar_ctrl_pkg::REG_ZERO;
      cvl_r <= sar_ctrl_pkg::REG_ZERO;
      pc3_r <= sar_ctrl_pkg::PC3_RESET;
    end
    else
    begin
      // Done flag: set wins over the clear that a control 1 write makes
      if (wr_sc1)
        sc1_r <= {1'b0, PWDATA_I[6:0]};
      if (xfer)
        sc1_r[sar_ctrl_pkg::SC1_DONE_BIT] <= 1'b1;
      if (wr_sc2)
        sc2_r <= {2'h0, PWDATA_I[5:4], 4'h0} | {1'b0, PWDATA_I[6], 6'h00};
      if (wr_cfg)
        cfg_r <= PWDATA_I[7:0];
      if (wr_cvh)
        cvh_r <= {6'h00, PWDATA_I[1:0]};
      if (wr_cvl)
        cvl_r <= PWDATA_I[7:0];
      if (wr_pc3)
        pc3_r <= PWDATA_I[7:0];
    end
  end

  // Result registers keep the last good value across aborts
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      rh_r      <= sar_ctrl_pkg::REG_ZERO;
      rl_r      <= sar_ctrl_pkg::REG_ZERO;
      hi_read_r <= 1'b0;
    end
    else
    begin
      if (xfer)
      begin
        rh_r <= ten ? {6'h00, result[9:8]} : sar_ctrl_pkg::REG_ZERO;
        rl_r <= result[7:0];
      end
      if (rd_rl || !ten)
        hi_read_r <= 1'b0;
      else if (rd_rh)
        hi_read_r <= 1'b1;
    end
  end

  // APB answers in the access cycle; outputs registered
  wire [7:0] rdata =
    (PADDR_I == sar_ctrl_pkg::ADDR_SC1)    ? sc1_r :
    (PADDR_I == sar_ctrl_pkg::ADDR_SC2)    ?
      (sc2_r | {tk.run, 7'h00}) :
    (PADDR_I == sar_ctrl_pkg::ADDR_RES_HI) ? rh_r :
    (PADDR_I == sar_ctrl_pkg::ADDR_RES_LO) ? rl_r :
    (PADDR_I == sar_ctrl_pkg::ADDR_CV_HI)  ? cvh_r :
    (PADDR_I == sar_ctrl_pkg::ADDR_CV_LO)  ? cvl_r :
    (PADDR_I == sar_ctrl_pkg::ADDR_CFG)    ? cfg_r :
    (PADDR_I == sar_ctrl_pkg::ADDR_PC3)    ? pc3_r : sar_ctrl_pkg::REG_ZERO;

  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      PRDATA_O       <= 32'h0000_0000;
      PREADY_O       <= 1'b0;
      PSLVERR_O      <= 1'b0;
      CHANNEL_O      <= sar_ctrl_pkg::CH_RESET;
      SAMPLE_O       <= 1'b0;
      DAC_CODE_O     <= 11'h000;
      ANALOG_EN_O    <= 1'b0;
      LOW_POWER_O    <= 1'b0;
      ASYNC_CLK_EN_O <= 1'b0;
      PIN_DISABLE_O  <= sar_ctrl_pkg::PC3_RESET;
      IRQ_O          <= 1'b0;
    end
    else
    begin
      PREADY_O       <= PSEL_I & ~PENABLE_I;
      PSLVERR_O      <= PSEL_I & ~PENABLE_I & ~mapped;
      PRDATA_O       <= {24'h000000, rdata};
      CHANNEL_O      <= ch;
      SAMPLE_O       <= st_nxt == sar_ctrl_pkg::ST_SAMPLE;
      DAC_CODE_O     <= sar_nxt;
      // Analog core powered only while converting
      ANALOG_EN_O    <= tk.run & ~ch_off;
      LOW_POWER_O    <= cfg_r[sar_ctrl_pkg::CFG_LPC_BIT];
      // Async clock on only while converting with it selected; wait and
      // stop do not gate it, which lets conversions run there
      ASYNC_CLK_EN_O <= async_s & tk.run;
      PIN_DISABLE_O  <= pc3_r;
      IRQ_O          <= sc1_r[sar_ctrl_pkg::SC1_DONE_BIT] &
                        sc1_r[sar_ctrl_pkg::SC1_IEN_BIT];
    end
  end

  a_abort_idles: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    (mode_ab && !start) |=> st_r == sar_ctrl_pkg::ST_IDLE)
    else $error("mode change did not abort");
  a_block_keeps: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    (last_bit && blocked) |=> $stable(rl_r) && $stable(rh_r))
    else $error("blocked result overwrote registers");
  a_done_sets: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    xfer |=> sc1_r[sar_ctrl_pkg::SC1_DONE_BIT])
    else $error("done flag not set on transfer");
  a_irq_follows: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    (xfer && sc1_r[sar_ctrl_pkg::SC1_IEN_BIT] && !wr_sc1) |=> ##1 IRQ_O)
    else $error("interrupt missing");
  a_async_gate: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    ASYNC_CLK_EN_O |-> $past(async_s) && $past(tk.run))
    else $error("async clock on without conversion");
  a_eight_low: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    (xfer && !ten) |=> rh_r == sar_ctrl_pkg::REG_ZERO)
    else $error("8-bit result leaked to high register");
  a_cmp_gate: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    (last_bit && cmp_en && !cmp_ok) |=> $stable(rl_r))
    else $error("failed compare stored result");
  a_off_idle: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    (st_r == sar_ctrl_pkg::ST_IDLE && ch_off && !hw_trg) |=>
      st_r == sar_ctrl_pkg::ST_IDLE || $past(wr_sc1))
    else $error("disabled converter started");
endmodule // sar_adc_ctrl

// File: hw/sar_ctrl_pkg.sv
// Package: register map, field layout, reset values and timing constants
package sar_ctrl_pkg;
  // Register byte offsets on the APB bus
  localparam logic [7:0] ADDR_SC1     = 8'h00;
  localparam logic [7:0] ADDR_SC2     = 8'h04;
  localparam logic [7:0] ADDR_RES_HI  = 8'h08;
  localparam logic [7:0] ADDR_RES_LO  = 8'h0c;
  localparam logic [7:0] ADDR_CV_HI   = 8'h10;
  localparam logic [7:0] ADDR_CV_LO   = 8'h14;
  localparam logic [7:0] ADDR_CFG     = 8'h18;
  localparam logic [7:0] ADDR_PC3     = 8'h1c;

  // status_control_1 fields
  localparam int SC1_DONE_BIT = 7;
  localparam int SC1_IEN_BIT  = 6;
  localparam int SC1_CONT_BIT = 5;
  localparam int CH_W         = 5;
  localparam logic [4:0] CH_ALL_ONES = 5'h1f;
  localparam logic [4:0] CH_RESET    = 5'h1f;

  // status_control_2 fields
  localparam int SC2_ACT_BIT  = 7;
  localparam int SC2_TRG_BIT  = 6;
  localparam int SC2_CFE_BIT  = 5;
  localparam int SC2_CFGT_BIT = 4;

  // configuration_reg fields
  localparam int CFG_LPC_BIT  = 7;
  localparam int CFG_DIV_LSB  = 5;
  localparam int CFG_LSMP_BIT = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_CLK_LSB  = 0;
  localparam logic [1:0] MODE_8   = 2'h0;
  localparam logic [1:0] MODE_10  = 2'h2;

  // clock_source_select encodings
  localparam logic [1:0] CLK_BUS      = 2'h0;
  localparam logic [1:0] CLK_BUS_HALF = 2'h1;
  localparam logic [1:0] CLK_ALT      = 2'h2;
  localparam logic [1:0] CLK_ASYNC    = 2'h3;

  // Sample lengths in converter clocks
  localparam logic [4:0] SAMPLE_SHORT = 5'h03;
  localparam logic [4:0] SAMPLE_LONG  = 5'h17;

  localparam logic [7:0] REG_ZERO     = 8'h00;
  localparam logic [7:0] PC3_RESET    = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_CONV   = 4'b0100,
    ST_DONE   = 4'b1000
  } conv_state_t;
endpackage

// File: hw/sar_tick_if.sv
// Interface: converter clock tick from divider to sequencer
`timescale 1ns/1ps
interface sar_tick_if;
  logic       run;
  logic [1:0] src;
  logic [1:0] div;
  logic       alt_tick;
  logic       async_tick;
  logic       tick;
  modport ctrl (output run, output src, output div, output alt_tick,
                output async_tick, input tick);
  modport gen  (input run, input src, input div, input alt_tick,
                input async_tick, output tick);
endinterface

// File: hw/sar_clk_div.sv
// Converter clock enable: source select and divide
`timescale 1ns/1ps
module sar_clk_div
(
  input  wire logic CLK_I,
  input  wire logic RESET_N_I,
  sar_tick_if.gen   t
);
  logic [4:0] cnt_r;
  logic       half_r;
  wire        src_ev;
  wire  [4:0] limit;

  assign src_ev = (t.src == sar_ctrl_pkg::CLK_BUS)      ? 1'b1 :
                  (t.src == sar_ctrl_pkg::CLK_BUS_HALF) ? half_r :
                  (t.src == sar_ctrl_pkg::CLK_ALT)      ? t.alt_tick :
                  t.async_tick;
  // Ratio 1,2,4,8; with the halved bus clock this reaches 16
  assign limit = 5'((5'h01 << t.div) - 5'h01);

  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      cnt_r  <= 5'h00;
      half_r <= 1'b0;
      t.tick <= 1'b0;
    end
    else
    begin
      half_r <= ~half_r & t.run;
      t.tick <= 1'b0;
      if (!t.run)
        cnt_r <= 5'h00;
      else if (src_ev)
      begin
        if (cnt_r >= limit)
        begin
          cnt_r  <= 5'h00;
          t.tick <= 1'b1;
        end
        else
          cnt_r <= 5'(cnt_r + 5'h01);
      end
    end
  end
endmodule // sar_clk_div

// File: test/sar_analog_model.sv
// Analog side model: channel levels, sample hold, comparator, async clock
`timescale 1ns/1ps
module sar_analog_model
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [4:0]  ch_i,
  input  wire logic        sample_i,
  input  wire logic [10:0] code_i,
  input  wire logic        en_i,
  input  wire logic        async_en_i,
  output logic             comp_o,
  output logic             async_tick_o
);
  logic [10:0] lvl [0:31];
  logic [10:0] held_r;
  logic [1:0]  div_r;
  logic        flip_r;
  // Unpowered comparator toggles, so a stale level never looks valid
  assign comp_o = en_i ? (held_r >= code_i) : flip_r;
  // Ticks only while the block enables the generator
  assign async_tick_o = async_en_i && (div_r == 2'h2);
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      held_r <= 11'h000;
      div_r  <= 2'h0;
      flip_r <= 1'b0;
    end
    else
    begin
      flip_r <= ~flip_r;
      if (sample_i)
        held_r <= lvl[ch_i];
      div_r <= async_en_i ? div_r + 2'h1 : 2'h0;
    end
  end
endmodule // sar_analog_model

// File: test/tb_top.sv
// Testbench: APB driven checks of the conversion control block
`timescale 1ns/1ps
module tb_top;
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
  logic        alt = 0, trg = 0, stp = 0, wt = 0, pready, serr, samp;
  logic        atick, comp, aen, lp, aclk, irq, qe;
  logic [7:0]  paddr = 0, pind, a4 [0:3];
  logic [31:0] pwdata = 0, prdata, q, d4 [0:3];
  logic [4:0]  ch;
  logic [10:0] code;
  int          error_cnt = 0, n_compared = 0, cyc = 0, t, n;

  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) alt <= (cyc % 7 == 0);

  sar_adc_ctrl sar_adc_ctrl_i (.CLK_I(clk), .RESET_N_I(rst_n),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(serr), .ALT_TICK_I(alt), .ASYNC_TICK_I(atick),
    .HW_TRIGGER_I(trg), .STOP_I(stp), .WAIT_I(wt), .COMP_I(comp),
    .CHANNEL_O(ch), .SAMPLE_O(samp), .DAC_CODE_O(code), .ANALOG_EN_O(aen),
    .LOW_POWER_O(lp), .ASYNC_CLK_EN_O(aclk), .PIN_DISABLE_O(pind),
    .IRQ_O(irq));
  sar_analog_model model_i (.clk_i(clk), .rst_n_i(rst_n), .ch_i(ch),
    .sample_i(samp), .code_i(code), .en_i(aen), .async_en_i(aclk),
    .comp_o(comp), .async_tick_o(atick));

  task automatic chk(input logic [31:0] g, e, input string m);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Request held until pready is seen at a rising edge; data taken there
  task automatic apb(input logic w, input logic [7:0] a, input [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 20)
      chk(0, 1, "no ready");
    q = prdata;
    qe = serr;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input [31:0] e);
    apb(0, a, 0);
    chk(q, e, "read");
  endtask
  task automatic wr(input logic [7:0] a, input [31:0] d);
    apb(1, a, d);
  endtask
  // Polls control 1 until the done flag sets, giving up after 200 reads
  task automatic wait_done();
    int k;
    k = 0;
    q = 0;
    while (q[7] !== 1'b1 && k < 200)
    begin
      apb(0, sar_ctrl_pkg::ADDR_SC1, 0);
      k++;
    end
    chk(k < 200, 1, "no done");
  endtask
  task automatic chk_res(input logic [10:0] v);
    logic [11:0] s;
    s = {1'b0, v} + 12'h001;
    if (s[11])
      s = 12'h7fe;
    rd(sar_ctrl_pkg::ADDR_RES_HI, {30'h0, s[10:9]});
    rd(sar_ctrl_pkg::ADDR_RES_LO, {24'h0, s[8:1]});
  endtask
  // 8-bit mode: rounded byte in the low register only
  task automatic chk_res8(input logic [8:0] v);
    logic [9:0] s;
    s = {1'b0, v} + 10'h001;
    if (s[9])
      s = 10'h1fe;
    rd(sar_ctrl_pkg::ADDR_RES_HI, 0);
    rd(sar_ctrl_pkg::ADDR_RES_LO, {24'h0, s[8:1]});
  endtask

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #1000000;
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    model_i.lvl[3] = 11'h2a5;
    model_i.lvl[4] = 11'h7ff;
    model_i.lvl[5] = 11'h0a0;
    model_i.lvl[6] = 11'h000;
    repeat (5) @(posedge clk);
    rst_n <= 1;
    rd(sar_ctrl_pkg::ADDR_SC1, 32'h1f);
    rd(sar_ctrl_pkg::ADDR_CFG, 0);
    chk_res(11'h000);
    chk(aen, 0, "enabled");
    rd(8'h40, 0);
    chk(qe, 1, "no slverr");
    wr(sar_ctrl_pkg::ADDR_PC3, 32'h03);
    rd(sar_ctrl_pkg::ADDR_PC3, 32'h03);
    chk(pind, 8'h03, "pins");
    $display("test registers done");
    wr(sar_ctrl_pkg::ADDR_CFG, 32'h08);
    wr(sar_ctrl_pkg::ADDR_SC1, 32'h43);
    wait_done();
    chk(irq, 1, "irq");
    chk_res(11'h2a5);
    chk(aen, 0, "not idle");
    wr(sar_ctrl_pkg::ADDR_SC1, 32'h1f);
    // Flag clears at the write edge, the registered pin one edge later
    repeat (2) @(posedge clk);
    chk(irq, 0, "irq held");
    wr(sar_ctrl_pkg::ADDR_CFG, 32'h00);
    wr(sar_ctrl_pkg::ADDR_SC1, 32'h04);
    wait_done();
    chk_res8(9'h1ff);
    for (int l = 0; l < 2; l++)
    begin
      wr(sar_ctrl_pkg::ADDR_CFG, 32'h08 | (l << 4));
      wr(sar_ctrl_pkg::ADDR_SC1, 32'h03);
      n = 0;
      t = 0;
      while (samp !== 1'b1 && t < 10)
      begin
        @(negedge clk);
        t++;
      end
      while (samp === 1'b1 && n < 40)
      begin
        @(negedge clk);
        n++;
      end
      // Sample ticks, the tick that ends sampling, and the entry cycle before the first tick
      chk(n, (l ? sar_ctrl_pkg::SAMPLE_LONG : sar_ctrl_pkg::SAMPLE_SHORT) + 2,
          "sample len");
      wait_done();
    end
    $display("test modes done");
    for (int i = 0; i < 4; i++)
    begin
      wr(sar_ctrl_pkg::ADDR_CFG, 32'h08 | ((i == 1 ? 3 : i == 2) << 5) | i);
      chk(aclk, 0, "async early");
      t = cyc;
      wr(sar_ctrl_pkg::ADDR_SC1, 32'h03);
      stp <= (i == 3);
      wt <= (i == 3);
      repeat (2) @(posedge clk);
      chk(aclk, i == 3, "async en");
      wait_done();
      stp <= 0;
      wt <= 0;
      chk_res(11'h2a5);
      chk(i != 1 || cyc - t >= 224, 1, "div16");
      chk(aclk, 0, "async late");
    end
    $display("test clocks done");
    a4 = '{sar_ctrl_pkg::ADDR_SC2, sar_ctrl_pkg::ADDR_CFG,
           sar_ctrl_pkg::ADDR_CV_HI, sar_ctrl_pkg::ADDR_CV_LO};
    d4 = '{0, 32'h18, 1, 0};
    wr(sar_ctrl_pkg::ADDR_CFG, 32'h18);
    for (int i = 0; i < 5; i++)
    begin
      wr(sar_ctrl_pkg::ADDR_SC1, 32'h04);
      repeat (4) @(posedge clk);
      if (i == 4)
        stp <= 1;
      else
        wr(a4[i], d4[i]);
      repeat (2) @(posedge clk);
      stp <= 0;
      repeat (80) @(posedge clk);
      rd(sar_ctrl_pkg::ADDR_SC1, 32'h04);
      chk(aen, 0, "abort");
      chk_res(11'h2a5);
    end
    wr(sar_ctrl_pkg::ADDR_SC1, 32'h05);
    repeat (4) @(posedge clk);
    wr(sar_ctrl_pkg::ADDR_SC1, 32'h04);
    wait_done();
    chk_res(11'h7ff);
    $display("test aborts done");
    for (int k = 0; k < 3; k++)
    begin
      wr(sar_ctrl_pkg::ADDR_SC2, k == 1 ? 32'h30 : 32'h20);
      wr(sar_ctrl_pkg::ADDR_SC1, k == 2 ? 5 : 3);
      repeat (80) @(posedge clk);
      rd(sar_ctrl_pkg::ADDR_SC1, k ? (k == 2 ? 32'h85 : 32'h83) : 3);
      chk(aen, 0, "single end");
      if (k == 1)
        chk_res(11'h2a5);
    end
    chk_res(11'h0a0);
    wr(sar_ctrl_pkg::ADDR_SC2, 0);
    wr(sar_ctrl_pkg::ADDR_CFG, 32'h08);
    wr(sar_ctrl_pkg::ADDR_SC1, 32'h06);
    rd(sar_ctrl_pkg::ADDR_RES_HI, 0);
    repeat (60) @(posedge clk);
    rd(sar_ctrl_pkg::ADDR_SC1, 32'h06);
    chk(aen, 1, "no restart");
    rd(sar_ctrl_pkg::ADDR_RES_LO, 32'h50);
    wait_done();
    chk_res(11'h000);
    $display("test compare and blocking done");
    wr(sar_ctrl_pkg::ADDR_SC1, 32'h23);
    wait_done();
    t = 0;
    while (samp !== 1'b1 && t < 60)
    begin
      @(negedge clk);
      t++;
    end
    chk(t < 60, 1, "continuous");
    wr(sar_ctrl_pkg::ADDR_SC1, 32'h1f);
    repeat (3) @(posedge clk);
    chk(aen, 0, "off");
    wr(sar_ctrl_pkg::ADDR_SC2, 32'h40);
    wr(sar_ctrl_pkg::ADDR_SC1, 32'h04);
    repeat (40) @(posedge clk);
    rd(sar_ctrl_pkg::ADDR_SC1, 32'h04);
    trg <= 1;
    repeat (2) @(posedge clk);
    trg <= 0;
    wait_done();
    chk_res(11'h7ff);
    wr(sar_ctrl_pkg::ADDR_SC1, 32'h03);
    repeat (4) @(posedge clk);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    chk_res(11'h000);
    rd(sar_ctrl_pkg::ADDR_SC1, 32'h1f);
    $display("test trigger and reset done");
    end_of_test();
  end
endmodule // tb_top
